// File: core/i2cms_pkg.sv
package i2cms_pkg;
    // Register indices on the plain register port
    localparam logic [2:0] CTRL1_ADDR  = 3'h0;
    localparam logic [2:0] CTRL2_ADDR  = 3'h1;
    localparam logic [2:0] STATUS_ADDR = 3'h2;
    localparam logic [2:0] BUFFER_ADDR = 3'h3;
    localparam logic [2:0] RELOAD_ADDR = 3'h4;
    localparam logic [2:0] FLAGS_ADDR  = 3'h5;

    // control_reg_one fields
    localparam int          WRITE_COLLISION_FLAG_BIT     = 7;
    localparam int          ENABLE_BIT   = 5;
    localparam logic [3:0]  MODE_MASTER  = 4'h8;
    // control_reg_two fields
    localparam int          ACKRX_BIT    = 6;
    localparam int          STOPREQ_BIT  = 2;
    localparam int          RESTART_BIT  = 1;
    localparam int          START_BIT    = 0;
    localparam logic [7:0]  CTRL2_WMASK  = 8'h1F;
    // port_status_reg fields
    localparam int          STOPSEEN_BIT = 4;
    localparam int          STARTSEEN_BIT = 3;
    localparam int          BUFFULL_BIT  = 0;
    // Flags register fields, write one to clear
    localparam int          IRQ_BIT      = 0;
    localparam int          BCOL_BIT     = 1;

    // Reset values
    localparam logic [7:0]  CTRL1_RESET  = 8'h00;
    localparam logic [7:0]  RELOAD_RESET = 8'h00;

    // Timing: counter steps on two of the four phases of an instruction cycle
    localparam int          PHASES_PER_CYCLE = 4;
    localparam int          BAUD_BITS    = 7;
    localparam int          BYTE_BITS    = 9;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0000,
        ST_SWAIT   = 4'b0001,
        ST_SHOLD   = 4'b0011,
        ST_RLOW    = 4'b0010,
        ST_RSDAHI  = 4'b0110,
        ST_RSCLREL = 4'b0111,
        ST_RBOTHHI = 4'b0101,
        ST_RSDALO  = 4'b0100,
        ST_TLOW    = 4'b1100,
        ST_TREL    = 4'b1101,
        ST_THIGH   = 4'b1111,
        ST_PLOW    = 4'b1110,
        ST_PWAIT   = 4'b1010,
        ST_PSCL    = 4'b1011,
        ST_PHIGH   = 4'b1001,
        ST_PEND    = 4'b1000
    } i2cms_state_t;
endpackage

// File: core/i2cms_sync.sv
module i2cms_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Asynchronous level in, synchronous level out
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic stage1_reg;

    // Two flops; the first one feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            stage1_reg <= 1'b1;
            syncOut    <= 1'b1;
        end else begin
            stage1_reg <= asyncIn;
            syncOut    <= stage1_reg;
        end
    end
endmodule

// File: core/i2cms_baud.sv
module i2cms_baud #(
    parameter int WIDTH = 7
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Reload and count control
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] loadVal,
    input  wire logic             step,
    // Count state
    output logic                  atZero
);
    logic [WIDTH-1:0] count_reg;

    initial begin
        if (WIDTH < 6) $error("baud counter too narrow");
    end

    // Reload wins; otherwise count down and hold at zero
    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg <= '0;
        end else if (load) begin
            count_reg <= loadVal;
        end else if (step && count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    // Plain count test; gating with load would loop back through the reload decode
    assign atZero = (count_reg == '0);
endmodule

// File: core/i2cms_master.sv
// The placing of the registers and the strobed register port were left to the implementer.
module i2cms_master #(
    parameter int BAUD_WIDTH = i2cms_pkg::BAUD_BITS
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Register port
    input  wire logic [2:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic      [7:0] regRdData,
    // Serial clock line
    input  wire logic       sclIn,
    output logic            sclOut,
    output logic            sclOe,
    // Serial data line
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe
);
    initial begin
        if (BAUD_WIDTH != i2cms_pkg::BAUD_BITS) $error("baud width must be seven");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers and state
    logic [7:0] ctrl1_reg;
    logic       startReq_reg;
    logic       restartReq_reg;
    logic       stopReq_reg;
    logic       ackRx_reg;
    logic       write_collision_flag_reg;
    logic       irq_reg;
    logic       bcol_reg;
    logic       startSeen_reg;
    logic       stopSeen_reg;
    logic       bufFull_reg;
    logic [7:0] reload_reg;
    logic [7:0] buffer_reg;
    logic [7:0] shift_reg;
    logic [3:0] bitCnt_reg;
    logic [1:0] phase_reg;
    logic       sclPrev_reg;
    logic       sdaPrev_reg;
    i2cms_pkg::i2cms_state_t state_reg;

    logic       sclS;
    logic       sdaS;
    logic       masterOn;
    logic       idle;
    logic       bufWrite;
    logic       bufAccept;
    logic       brgLoad;
    logic [6:0] brgVal;
    logic       brgZero;
    logic       collide;
    logic       startDone;
    logic       restartDone;
    logic       byteDone;
    logic       stopDone;

    ////////////////////////////////////////////////////////////////////////////
    // Line synchronisers
    i2cms_sync u_sclSync (.clk(clk), .rst(rst), .asyncIn(sclIn), .syncOut(sclS));
    i2cms_sync u_sdaSync (.clk(clk), .rst(rst), .asyncIn(sdaIn), .syncOut(sdaS));

    // Instruction-cycle phases; steps land on phases 1 and 3
    always_ff @(posedge clk) begin
        if (rst) begin
            phase_reg <= 2'h0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
        end
    end

    i2cms_baud #(.WIDTH(BAUD_WIDTH)) u_baud (
        .clk    (clk),
        .rst    (rst),
        .load   (brgLoad),
        .loadVal(brgVal),
        .step   (phase_reg[0]),
        .atZero (brgZero)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Decode of mode, idle and buffer writes
    assign masterOn  = ctrl1_reg[i2cms_pkg::ENABLE_BIT] && ctrl1_reg[3:0] == i2cms_pkg::MODE_MASTER;
    assign idle      = state_reg == i2cms_pkg::ST_IDLE && !startReq_reg && !restartReq_reg && !stopReq_reg;
    assign bufWrite  = regWr && regAddr == i2cms_pkg::BUFFER_ADDR;
    assign bufAccept = bufWrite && idle && masterOn;
    assign startDone   = state_reg == i2cms_pkg::ST_SHOLD && brgZero;
    assign restartDone = state_reg == i2cms_pkg::ST_RSDALO && brgZero;
    assign byteDone    = state_reg == i2cms_pkg::ST_THIGH && brgZero && bitCnt_reg == 4'h8;
    assign stopDone    = state_reg == i2cms_pkg::ST_PEND && brgZero;

    // Collision checks for start and restart sequences
    always_comb begin
        collide = 1'b0;
        case (state_reg)
            i2cms_pkg::ST_IDLE:    collide = masterOn && startReq_reg && !sclS && !sdaS;
            i2cms_pkg::ST_SWAIT:   collide = !sclS;
            i2cms_pkg::ST_RSDAHI:  collide = brgZero && !sdaS;
            i2cms_pkg::ST_RSCLREL: collide = sclS && !sdaS;
            i2cms_pkg::ST_RBOTHHI: collide = !sclS || !sdaS;
            default:               collide = 1'b0;
        endcase
    end

    // Counter reloads; full seven bits except the restart low phase
    always_comb begin
        brgLoad = 1'b0;
        brgVal  = reload_reg[6:0];
        case (state_reg)
            i2cms_pkg::ST_IDLE:    brgLoad = masterOn && startReq_reg && sclS && sdaS;
            i2cms_pkg::ST_SWAIT:   brgLoad = brgZero && sclS && sdaS;
            i2cms_pkg::ST_RLOW: begin
                brgLoad = !sclS;
                brgVal  = {1'b0, reload_reg[5:0]};
            end
            i2cms_pkg::ST_RSCLREL: brgLoad = sclS && sdaS;
            i2cms_pkg::ST_RBOTHHI: brgLoad = brgZero && sclS && sdaS;
            i2cms_pkg::ST_TREL:    brgLoad = sclS;
            i2cms_pkg::ST_THIGH:   brgLoad = brgZero && bitCnt_reg != 4'h8;
            i2cms_pkg::ST_PLOW:    brgLoad = !sdaS;
            i2cms_pkg::ST_PSCL:    brgLoad = sclS;
            i2cms_pkg::ST_PHIGH:   brgLoad = brgZero;
            default:               brgLoad = 1'b0;
        endcase
        if (bufAccept) begin
            brgLoad = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer and line drive; only ever pulls low or releases
    always_ff @(posedge clk) begin
        if (rst || !masterOn) begin
            state_reg <= i2cms_pkg::ST_IDLE;
            sclOe     <= 1'b0;
            sdaOe     <= 1'b0;
        end else if (collide) begin
            state_reg <= i2cms_pkg::ST_IDLE;
            sclOe     <= 1'b0;
            sdaOe     <= 1'b0;
        end else begin
            case (state_reg)
                i2cms_pkg::ST_IDLE: begin
                    if (bufAccept) begin
                        state_reg <= i2cms_pkg::ST_TLOW;
                        sclOe     <= 1'b1;
                        sdaOe     <= !regWrData[7];
                    end else if (startReq_reg && sclS && sdaS) begin
                        state_reg <= i2cms_pkg::ST_SWAIT;
                    end else if (restartReq_reg) begin
                        state_reg <= i2cms_pkg::ST_RLOW;
                        sclOe     <= 1'b1;
                    end else if (stopReq_reg) begin
                        state_reg <= i2cms_pkg::ST_PLOW;
                        sdaOe     <= 1'b1;
                    end
                end
                i2cms_pkg::ST_SWAIT: begin
                    if (brgZero && sdaS) begin
                        state_reg <= i2cms_pkg::ST_SHOLD;
                        sdaOe     <= 1'b1;
                    end
                end
                i2cms_pkg::ST_SHOLD: begin
                    if (brgZero) begin
                        state_reg <= i2cms_pkg::ST_IDLE;
                    end
                end
                i2cms_pkg::ST_RLOW: begin
                    if (!sclS) begin
                        state_reg <= i2cms_pkg::ST_RSDAHI;
                        sdaOe     <= 1'b0;
                    end
                end
                i2cms_pkg::ST_RSDAHI: begin
                    if (brgZero) begin
                        state_reg <= i2cms_pkg::ST_RSCLREL;
                        sclOe     <= 1'b0;
                    end
                end
                i2cms_pkg::ST_RSCLREL: begin
                    if (sclS) begin
                        state_reg <= i2cms_pkg::ST_RBOTHHI;
                    end
                end
                i2cms_pkg::ST_RBOTHHI: begin
                    if (brgZero) begin
                        state_reg <= i2cms_pkg::ST_RSDALO;
                        sdaOe     <= 1'b1;
                    end
                end
                i2cms_pkg::ST_RSDALO: begin
                    if (brgZero) begin
                        state_reg <= i2cms_pkg::ST_IDLE;
                    end
                end
                i2cms_pkg::ST_TLOW: begin
                    if (brgZero) begin
                        state_reg <= i2cms_pkg::ST_TREL;
                        sclOe     <= 1'b0;
                    end
                end
                i2cms_pkg::ST_TREL: begin
                    if (sclS) begin
                        state_reg <= i2cms_pkg::ST_THIGH;
                    end
                end
                i2cms_pkg::ST_THIGH: begin
                    if (brgZero) begin
                        sclOe <= 1'b1;
                        if (bitCnt_reg == 4'h8) begin
                            state_reg <= i2cms_pkg::ST_IDLE;
                        end else begin
                            state_reg <= i2cms_pkg::ST_TLOW;
                            sdaOe     <= bitCnt_reg != 4'h7 && !shift_reg[6];
                        end
                    end
                end
                i2cms_pkg::ST_PLOW: begin
                    if (!sdaS) begin
                        state_reg <= i2cms_pkg::ST_PWAIT;
                    end
                end
                i2cms_pkg::ST_PWAIT: begin
                    if (brgZero) begin
                        state_reg <= i2cms_pkg::ST_PSCL;
                        sclOe     <= 1'b0;
                    end
                end
                i2cms_pkg::ST_PSCL: begin
                    if (sclS) begin
                        state_reg <= i2cms_pkg::ST_PHIGH;
                    end
                end
                i2cms_pkg::ST_PHIGH: begin
                    if (brgZero) begin
                        state_reg <= i2cms_pkg::ST_PEND;
                        sdaOe     <= 1'b0;
                    end
                end
                default: begin
                    if (brgZero) begin
                        state_reg <= i2cms_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Open-drain data levels stay low; only the enables move
    always_ff @(posedge clk) begin
        if (rst) begin
            sclOut <= 1'b0;
            sdaOut <= 1'b0;
        end else begin
            sclOut <= 1'b0;
            sdaOut <= 1'b0;
        end
    end

    // Shifter and bit count for the address and data bytes, MSB first
    always_ff @(posedge clk) begin
        if (rst) begin
            shift_reg  <= 8'h00;
            bitCnt_reg <= 4'h0;
        end else if (bufAccept) begin
            shift_reg  <= regWrData;
            bitCnt_reg <= 4'h0;
        end else if (state_reg == i2cms_pkg::ST_THIGH && brgZero && bitCnt_reg != 4'h8) begin
            shift_reg  <= {shift_reg[6:0], 1'b0};
            bitCnt_reg <= bitCnt_reg + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus condition detectors on synchronised levels
    always_ff @(posedge clk) begin
        if (rst) begin
            sclPrev_reg <= 1'b1;
            sdaPrev_reg <= 1'b1;
        end else begin
            sclPrev_reg <= sclS;
            sdaPrev_reg <= sdaS;
        end
    end

    // Start-seen and stop-seen; cleared while the port is off
    always_ff @(posedge clk) begin
        if (rst || !ctrl1_reg[i2cms_pkg::ENABLE_BIT]) begin
            startSeen_reg <= 1'b0;
            stopSeen_reg  <= 1'b0;
        end else if (sclS && sclPrev_reg && sdaPrev_reg && !sdaS) begin
            startSeen_reg <= 1'b1;
            stopSeen_reg  <= 1'b0;
        end else if (sclS && sclPrev_reg && !sdaPrev_reg && sdaS) begin
            stopSeen_reg  <= 1'b1;
            startSeen_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software-visible control and the reload value
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl1_reg  <= i2cms_pkg::CTRL1_RESET;
            reload_reg <= i2cms_pkg::RELOAD_RESET;
        end else if (regWr && regAddr == i2cms_pkg::CTRL1_ADDR) begin
            ctrl1_reg  <= regWrData;
        end else if (regWr && regAddr == i2cms_pkg::RELOAD_ADDR) begin
            reload_reg <= regWrData;
        end
    end

    // Requests accepted only while idle; hardware clears them when done
    always_ff @(posedge clk) begin
        if (rst || !masterOn || collide) begin
            startReq_reg   <= 1'b0;
            restartReq_reg <= 1'b0;
            stopReq_reg    <= 1'b0;
        end else if (startDone) begin
            startReq_reg   <= 1'b0;
        end else if (restartDone) begin
            restartReq_reg <= 1'b0;
        end else if (stopDone) begin
            stopReq_reg    <= 1'b0;
        end else if (regWr && regAddr == i2cms_pkg::CTRL2_ADDR && idle) begin
            startReq_reg   <= regWrData[i2cms_pkg::START_BIT];
            restartReq_reg <= regWrData[i2cms_pkg::RESTART_BIT];
            stopReq_reg    <= regWrData[i2cms_pkg::STOPREQ_BIT];
        end
    end

    // Buffer, buffer-full and received acknowledge
    always_ff @(posedge clk) begin
        if (rst) begin
            buffer_reg  <= 8'h00;
            bufFull_reg <= 1'b0;
            ackRx_reg   <= 1'b0;
        end else begin
            if (bufAccept) begin
                buffer_reg <= regWrData;
            end
            if (bufAccept) begin
                bufFull_reg <= 1'b1;
            end else if (state_reg == i2cms_pkg::ST_THIGH && bitCnt_reg == 4'h7 && brgZero) begin
                bufFull_reg <= 1'b0;
            end
            if (byteDone) begin
                ackRx_reg <= sdaS;
            end
        end
    end

    // Sticky flags; a hardware set beats a software clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            write_collision_flag_reg <= 1'b0;
            irq_reg  <= 1'b0;
            bcol_reg <= 1'b0;
        end else begin
            if (bufWrite && !bufAccept) begin
                write_collision_flag_reg <= 1'b1;
            end else if (regWr && regAddr == i2cms_pkg::CTRL1_ADDR) begin
                write_collision_flag_reg <= regWrData[i2cms_pkg::WRITE_COLLISION_FLAG_BIT];
            end
            if (startDone || restartDone || byteDone || stopDone) begin
                irq_reg <= 1'b1;
            end else if (regWr && regAddr == i2cms_pkg::FLAGS_ADDR && regWrData[i2cms_pkg::IRQ_BIT]) begin
                irq_reg <= 1'b0;
            end
            if (collide && masterOn) begin
                bcol_reg <= 1'b1;
            end else if (regWr && regAddr == i2cms_pkg::FLAGS_ADDR && regWrData[i2cms_pkg::BCOL_BIT]) begin
                bcol_reg <= 1'b0;
            end
        end
    end

    // Read data, valid the cycle after the strobe only
    always_ff @(posedge clk) begin
        if (rst || !regRd) begin
            regRdData <= 8'h00;
        end else if (regAddr == i2cms_pkg::CTRL1_ADDR) begin
            regRdData <= {write_collision_flag_reg, ctrl1_reg[6:0]};
        end else if (regAddr == i2cms_pkg::CTRL2_ADDR) begin
            regRdData <= {1'b0, ackRx_reg, 3'h0, stopReq_reg, restartReq_reg, startReq_reg};
        end else if (regAddr == i2cms_pkg::STATUS_ADDR) begin
            regRdData <= {3'h0, stopSeen_reg, startSeen_reg, 2'h0, bufFull_reg};
        end else if (regAddr == i2cms_pkg::BUFFER_ADDR) begin
            regRdData <= buffer_reg;
        end else if (regAddr == i2cms_pkg::RELOAD_ADDR) begin
            regRdData <= reload_reg;
        end else if (regAddr == i2cms_pkg::FLAGS_ADDR) begin
            regRdData <= {6'h00, bcol_reg, irq_reg};
        end else begin
            regRdData <= 8'h00;
        end
    end
endmodule

// File: sim/i2cms_slave_model.sv
module i2cms_slave_model (
    // Bus wires
    input  wire logic       scl,
    input  wire logic       sda,
    // Behaviour chosen by the bench
    input  wire logic       ackOn,
    input  wire logic       stretchOn,
    input  wire logic       jamBus,
    // Pulls, high = line low
    output logic            sclPull,
    output logic            sdaPull,
    // Last byte seen
    output logic      [7:0] rxByte
);
    timeunit 1ns;
    timeprecision 1ns;
    int         bitCnt = 0;
    logic       ackPull = 1'b0;
    logic       sclHold = 1'b0;
    logic [7:0] shiftIn = 8'h00;
    // Start restarts the count; first fall then makes it zero
    always @(negedge sda) if (scl) bitCnt = -1;
    // Data is taken while the clock is high
    always @(posedge scl) if (bitCnt < 8) shiftIn = {shiftIn[6:0], sda};
    // Ack after the eighth bit; stretch off the edge grid to test the master's wait for a released clock
    always @(negedge scl) begin
        bitCnt = bitCnt + 1;
        if (bitCnt == 8) rxByte = shiftIn;
        ackPull = ackOn && bitCnt == 8;
        if (bitCnt == 9) bitCnt = 0;
        if (stretchOn) begin
            sclHold = 1'b1;
            #410 sclHold = 1'b0;
        end
    end
    assign sclPull = sclHold || jamBus;
    assign sdaPull = ackPull || jamBus;
endmodule

// File: sim/i2cms_master_asserts.sv
module i2cms_master_asserts (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // Register writes
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWr,
    // Lines
    input wire logic       sclIn,
    input wire logic       sclOut,
    input wire logic       sclOe,
    input wire logic       sdaOut,
    input wire logic       sdaOe
);
    logic [6:0]  rel;
    logic        on;
    logic [11:0] loCnt;
    logic [11:0] hiCnt;
    logic [11:0] holdCnt;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Mode and reload as last written
    always_ff @(posedge clk) begin
        if (rst) begin
            rel <= 7'h00;
            on <= 1'b0;
        end else if (regWr && regAddr == i2cms_pkg::RELOAD_ADDR) begin
            rel <= regWrData[6:0];
        end else if (regWr && regAddr == i2cms_pkg::CTRL1_ADDR) begin
            on <= regWrData[i2cms_pkg::ENABLE_BIT] && regWrData[3:0] == i2cms_pkg::MODE_MASTER;
        end
    end
    // Saturating phase lengths, so idle time never wraps
    always_ff @(posedge clk) begin
        loCnt <= sclOe ? loCnt + {11'h000, ~&loCnt} : 12'h000;
        hiCnt <= (!sclOe && sclIn) ? hiCnt + {11'h000, ~&hiCnt} : 12'h000;
        holdCnt <= (sdaOe && !sclOe) ? holdCnt + {11'h000, ~&holdCnt} : 12'h000;
    end
    property p_open_drain; !sclOut && !sdaOut; endproperty
    a_open_drain: assert property (p_open_drain) else $error("Line driven high");
    property p_off_quiet; !on |=> !sclOe && !sdaOe; endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("Lines pulled while off");
    property p_start_high; $rose(sdaOe) && !sclOe |-> sclIn; endproperty
    a_start_high: assert property (p_start_high) else $error("Data pulled with clock low");
    property p_low_time; $fell(sclOe) |-> loCnt >= 2 * rel[5:0]; endproperty
    a_low_time: assert property (p_low_time) else $error("Clock low too short");
    property p_high_time; $rose(sclOe) |-> hiCnt >= 2 * rel; endproperty
    a_high_time: assert property (p_high_time) else $error("Clock high too short");
    property p_hold_time; $rose(sclOe) && holdCnt != 0 |-> holdCnt >= 2 * rel; endproperty
    a_hold_time: assert property (p_hold_time) else $error("Start hold too short");
    property p_stop_time; $fell(sdaOe) && !sclOe |-> hiCnt >= 2 * rel; endproperty
    a_stop_time: assert property (p_stop_time) else $error("Stop setup too short");
    property p_sync_lag; $rose(sclIn) |=> $stable(sclOe) && $stable(sdaOe); endproperty
    a_sync_lag: assert property (p_sync_lag) else $error("Reacted before sync");
    c_start: cover property ($rose(sdaOe) && !sclOe);
    c_stop: cover property ($fell(sdaOe) && !sclOe);
    c_stretch: cover property (!sclOe && !sclIn);
endmodule
bind i2cms_master i2cms_master_asserts u_chk (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe),
    .sdaOut(sdaOut), .sdaOe(sdaOe));

// File: sim/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [2:0] AC1 = i2cms_pkg::CTRL1_ADDR, AC2 = i2cms_pkg::CTRL2_ADDR;
    localparam logic [2:0] AST = i2cms_pkg::STATUS_ADDR, ABF = i2cms_pkg::BUFFER_ADDR;
    localparam logic [2:0] ARL = i2cms_pkg::RELOAD_ADDR, AFL = i2cms_pkg::FLAGS_ADDR;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] regWrData = 8'h00;
    logic       regWr = 1'b0;
    logic       regRd = 1'b0;
    logic       ackOn = 1'b1;
    logic       stretchOn = 1'b0;
    logic       jamBus = 1'b0;
    logic [7:0] regRdData, rxByte;
    logic       sclOe, sdaOe, sclPull, sdaPull;
    int         fails = 0;
    int         n_compared = 0;
    // Pull-ups resolve the open-drain wires
    wire scl = !(sclOe || sclPull);
    wire sda = !(sdaOe || sdaPull);
    i2cms_master DUT (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .sclIn(scl), .sclOut(), .sclOe(sclOe), .sdaIn(sda),
        .sdaOut(), .sdaOe(sdaOe));
    i2cms_slave_model slave (.scl(scl), .sda(sda), .ackOn(ackOn), .stretchOn(stretchOn),
        .jamBus(jamBus), .sclPull(sclPull), .sdaPull(sdaPull), .rxByte(rxByte));
    initial forever #20 clk = ~clk;
    ////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    // Data stands only in the cycle after the strobe
    task automatic rdRaw(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 v = regRdData;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
        logic [7:0] v;
        rdRaw(a, v);
        chk(n, e, v & m);
    endtask
    // Bounded poll; a reload wider than three bits can overrun it
    task automatic waitIrq(input string n);
        logic [7:0] v;
        v = 8'h00;
        for (int i = 0; i < 250 && v[0] !== 1'b1; i++) rdRaw(AFL, v);
        chk(n, 8'h01, v & 8'h01);
        wr(AFL, 8'h01);
    endtask
    task automatic end_of_test();
        if (fails == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        #400000;
        fails++;
        end_of_test();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(AC1, 8'hFF, 8'h00, "ctrl1 reset");
        rd(ARL, 8'hFF, 8'h00, "reload reset");
        rd(3'h6, 8'hFF, 8'h00, "unmapped");
        wr(AC2, 8'h01);
        repeat (60) @(posedge clk);
        rd(AFL, 8'hFF, 8'h00, "irq while off");
        chk("sda while off", 8'h01, {7'h00, sda});
        wr(AC2, 8'h00);
        wr(AC1, 8'h28);
        wr(ARL, 8'h82);
        // Stop request and buffer write during start must bounce
        wr(AC2, 8'h01);
        wr(AC2, 8'h04);
        wr(ABF, 8'hA5);
        waitIrq("start irq");
        rd(AST, 8'h08, 8'h08, "start seen");
        rd(AC2, 8'h07, 8'h00, "ctrl2 after start");
        rd(AC1, 8'h80, 8'h80, "write_collision_flag start");
        chk("lines after start", 8'h01, {6'h00, sda, scl});
        wr(AC1, 8'h28);
        stretchOn = 1'b1;
        wr(ABF, 8'hA4);
        wr(ABF, 8'h11);
        waitIrq("addr irq");
        stretchOn = 1'b0;
        chk("addr byte", 8'hA4, rxByte);
        rd(AC2, 8'h40, 8'h00, "ack");
        rd(AC1, 8'h80, 8'h80, "write_collision_flag byte");
        chk("scl parked", 8'h00, {7'h00, scl});
        wr(AC1, 8'h28);
        ackOn = 1'b0;
        wr(ABF, 8'h3C);
        wr(AC2, 8'h02);
        waitIrq("data irq");
        chk("data byte", 8'h3C, rxByte);
        rd(AC2, 8'h42, 8'h40, "nack no restart");
        ackOn = 1'b1;
        wr(AC2, 8'h02);
        wr(ABF, 8'h77);
        waitIrq("restart irq");
        rd(AC2, 8'h02, 8'h00, "restart cleared");
        rd(AC1, 8'h80, 8'h80, "write_collision_flag restart");
        chk("lines after restart", 8'h01, {6'h00, sda, scl});
        wr(AC1, 8'h28);
        wr(ABF, 8'hA5);
        waitIrq("read addr irq");
        chk("read addr", 8'hA5, rxByte);
        wr(AC2, 8'h04);
        waitIrq("stop irq");
        rd(AST, 8'h10, 8'h10, "stop seen");
        chk("lines after stop", 8'h03, {6'h00, sda, scl});
        wr(AC1, 8'h00);
        rd(AST, 8'h18, 8'h00, "seen flags off");
        wr(AC1, 8'h28);
        #5 jamBus = 1'b1;
        wr(AC2, 8'h01);
        repeat (20) @(posedge clk);
        rd(AFL, 8'h02, 8'h02, "collision");
        rd(AC2, 8'h01, 8'h00, "start aborted");
        jamBus = 1'b0;
        wr(AFL, 8'h03);
        rd(AFL, 8'h03, 8'h00, "flags cleared");
        end_of_test();
    end
endmodule
